// ---- clk_gen_pkg.sv ----
// Shared constants, field layouts and types of the clock generation control block
package clk_gen_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Indirect register indices
  localparam logic [4:0] IDX_LINE_TOTAL_TRIM    = 5'h09;
  localparam logic [4:0] IDX_SHARED_DIVIDERS    = 5'h0a;
  localparam logic [4:0] IDX_AUX_PLL_MACRO      = 5'h0b;
  localparam logic [4:0] IDX_DELAY_LOOP         = 5'h0c;
  localparam logic [4:0] IDX_AUX_CLOCK_FAMILY   = 5'h0d;
  localparam logic [4:0] IDX_ENGINE_PLL_MACRO   = 5'h0e;
  localparam logic [4:0] IDX_ENGINE_CLOCK       = 5'h0f;
  localparam logic [4:0] IDX_PORT_PLL           = 5'h10;
  localparam logic [4:0] IDX_CAPTURE_CLOCK      = 5'h12;
  localparam logic [4:0] IDX_PLL_TEST           = 5'h13;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_ZERO              = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_MACRO         = 32'h0000_cc03;
  localparam logic [31:0] RST_ENGINE_PLL_MACRO  = 32'h0000_cc03;
  localparam logic [31:0] RST_DELAY_LOOP        = 32'h000b_000b;
  localparam logic [31:0] RST_PORT_PLL          = 32'h0a77_0000;
  localparam logic [31:0] RST_CAPTURE_CLOCK     = 32'h0000_0404;
  localparam logic [31:0] RST_PLL_TEST          = 32'h0000_0200;

  // Writable bits; reserved bits stay zero
  localparam logic [31:0] MSK_LINE_TOTAL_TRIM   = 32'h1107_0f0f;
  localparam logic [31:0] MSK_SHARED_DIVIDERS   = 32'h00ff_ffff;
  localparam logic [31:0] MSK_PLL_MACRO         = 32'h0000_ff03;
  localparam logic [31:0] MSK_DELAY_LOOP        = 32'h77ff_77ff;
  localparam logic [31:0] MSK_AUX_CLOCK_FAMILY  = 32'h0000_ff77;
  localparam logic [31:0] MSK_ENGINE_CLOCK      = 32'h0007_0007;
  localparam logic [31:0] MSK_PORT_PLL          = 32'h0f77_0303;
  localparam logic [31:0] MSK_CAPTURE_CLOCK     = 32'h0000_0707;
  localparam logic [31:0] MSK_PLL_TEST          = 32'hff0f_0300;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_PIXEL_SLIP   = 0;
  localparam int POS_PHASE_SLIP   = 16;
  localparam int POS_SYNC_EDGE    = 24;
  localparam int POS_LEGACY_EN    = 28;
  localparam int POS_REF_DIV      = 0;
  localparam int POS_AUX_FB_DIV   = 8;
  localparam int POS_ENG_FB_DIV   = 16;
  localparam int POS_FORCE_2D     = 16;
  localparam int POS_CAPTURE_B    = 8;
  localparam int POS_INDEX_WR_EN  = 7;
  localparam int POS_DIV_SEL      = 8;

  localparam logic [7:0] MIN_DIVIDER      = 8'h02;
  localparam logic [2:0] PIXEL_SLIP_MAX   = 3'h7;
  localparam logic [2:0] CAPTURE_GROUND   = 3'h4;
  localparam logic [1:0] BAND_80_110      = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [2:0] aux_clock_source;
    logic [2:0] second_clock_source;
    logic [2:0] host_clk_pin_a_source;
    logic [2:0] host_clk_pin_b_source;
    logic [2:0] engine_clock_source;
    logic [2:0] capture_clk_a_source;
    logic [2:0] capture_clk_b_source;
  } clk_select_t;

  typedef struct packed {
    logic       sleep;
    logic       reset;
    logic [1:0] freq_band;
    logic [1:0] ref_select;
    logic [1:0] feedback_select;
  } dll_ctl_t;

  typedef struct packed {
    logic [7:0] shared_ref_divider;
    logic [7:0] aux_pll_feedback_divider;
    logic [7:0] engine_pll_feedback_divider;
  } pll_div_t;

  function automatic logic [31:0] reg_mask(input logic [4:0] idx);
    unique case (idx)
      IDX_LINE_TOTAL_TRIM:  reg_mask = MSK_LINE_TOTAL_TRIM;
      IDX_SHARED_DIVIDERS:  reg_mask = MSK_SHARED_DIVIDERS;
      IDX_AUX_PLL_MACRO,
      IDX_ENGINE_PLL_MACRO: reg_mask = MSK_PLL_MACRO;
      IDX_DELAY_LOOP:       reg_mask = MSK_DELAY_LOOP;
      IDX_AUX_CLOCK_FAMILY: reg_mask = MSK_AUX_CLOCK_FAMILY;
      IDX_ENGINE_CLOCK:     reg_mask = MSK_ENGINE_CLOCK;
      IDX_PORT_PLL:         reg_mask = MSK_PORT_PLL;
      IDX_CAPTURE_CLOCK:    reg_mask = MSK_CAPTURE_CLOCK;
      IDX_PLL_TEST:         reg_mask = MSK_PLL_TEST;
      default:              reg_mask = RST_ZERO;
    endcase
  endfunction : reg_mask

  function automatic logic [31:0] reg_reset(input logic [4:0] idx);
    unique case (idx)
      IDX_AUX_PLL_MACRO:    reg_reset = RST_PLL_MACRO;
      IDX_ENGINE_PLL_MACRO: reg_reset = RST_ENGINE_PLL_MACRO;
      IDX_DELAY_LOOP:       reg_reset = RST_DELAY_LOOP;
      IDX_PORT_PLL:         reg_reset = RST_PORT_PLL;
      IDX_CAPTURE_CLOCK:    reg_reset = RST_CAPTURE_CLOCK;
      IDX_PLL_TEST:         reg_reset = RST_PLL_TEST;
      default:              reg_reset = RST_ZERO;
    endcase
  endfunction : reg_reset

endpackage : clk_gen_pkg

// ---- clock_gate_ctrl.sv ----
// Dynamic clock gating enables with software force-on overrides
`timescale 1ns/1ns
`default_nettype none
module clock_gate_ctrl #(
  parameter int N = 3
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [N-1:0] force_on,
  input  wire logic [N-1:0] activity,
  output var  logic [N-1:0] clock_run
);
  import clk_gen_pkg::*;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clock_run <= '0;
    end else if (ce) begin
      clock_run <= force_on | activity;
    end
  end

  chk_force_runs: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> (clock_run & $past(force_on)) == $past(force_on))
    else $error("forced clock not running");
  chk_idle_gated: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> (clock_run & ~$past(force_on) & ~$past(activity)) == '0)
    else $error("idle clock not gated");

endmodule : clock_gate_ctrl
`default_nettype wire

// ---- clock_generation_control.sv ----
// Clock generation control: indirect register file, slip timing and clock tree settings
`timescale 1ns/1ns
`default_nettype none
module clock_generation_control (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Host access to the index and data registers
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_sel_data,
  input  wire logic [3:0]               reg_be,
  input  wire logic [31:0]              reg_wdata,
  output var  logic [31:0]              reg_rdata,
  output var  logic                     reg_rvalid,
  // Display timing
  input  wire logic                     hsync,
  input  wire logic                     extended_display_enable,
  input  wire logic                     sequencer_half_pixel_clock,
  output var  logic [3:0]               line_extra_pixels,
  output logic                          phase_slip_pulse,
  // Clock tree settings
  output var  clk_gen_pkg::pll_div_t    pll_div,
  output var  logic                     aux_pll_run,
  output var  logic                     engine_pll_run,
  output var  clk_gen_pkg::dll_ctl_t    dll_a,
  output var  clk_gen_pkg::dll_ctl_t    dll_b,
  output var  clk_gen_pkg::clk_select_t clk_select,
  input  wire logic [2:0]               engine_activity,
  output logic [2:0]                    engine_clock_run
);
  import clk_gen_pkg::*;

  function automatic logic div_ok(input logic [7:0] d);
    div_ok = (d >= MIN_DIVIDER);
  endfunction : div_ok

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
    byte_merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction : byte_merge

  //////////////////////////////////////////////////////////////////////////////
  // Index register and indirect register file
  logic [4:0]  index_addr;
  logic        index_wr_en;
  logic [1:0]  div_sel;
  logic [31:0] pll_regs [0:31];
  logic [31:0] index_word;
  logic        data_write;

  assign index_word = {22'h0, div_sel, index_wr_en, 2'h0, index_addr};
  assign data_write = ce && reg_wr && reg_sel_data && index_wr_en;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      index_addr  <= 5'h00;
      index_wr_en <= 1'b0;
      div_sel     <= 2'h0;
    end else if (ce && reg_wr && !reg_sel_data) begin
      if (reg_be[0]) begin
        index_addr  <= reg_wdata[4:0];
        index_wr_en <= reg_wdata[POS_INDEX_WR_EN];
      end
      if (reg_be[1]) begin
        div_sel <= reg_wdata[POS_DIV_SEL +: 2];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        pll_regs[i] <= reg_reset(5'(i));
      end
    end else if (data_write) begin
      pll_regs[index_addr] <= byte_merge(pll_regs[index_addr], reg_wdata, reg_be,
                                         reg_mask(index_addr));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= reg_sel_data ? pll_regs[index_addr] : index_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Horizontal total trim
  logic [31:0] trim;
  logic        legacy_mode;
  logic        slip_allowed;
  logic [2:0]  pixel_slip_count;
  logic [3:0]  next_line_extra_pixels;

  assign trim             = pll_regs[IDX_LINE_TOTAL_TRIM];
  assign legacy_mode      = !extended_display_enable;
  assign slip_allowed     = !legacy_mode || trim[POS_LEGACY_EN];
  // Field values above seven are held at seven
  assign pixel_slip_count = trim[POS_PIXEL_SLIP + 3] ? PIXEL_SLIP_MAX : trim[POS_PIXEL_SLIP +: 3];
  // The clock slip field at bits 11:8 is stored but steers nothing
  assign next_line_extra_pixels = (legacy_mode && sequencer_half_pixel_clock)
                                ? {pixel_slip_count, 1'b0}
                                : {1'b0, pixel_slip_count};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_extra_pixels <= 4'h0;
    end else if (ce) begin
      line_extra_pixels <= next_line_extra_pixels;
    end
  end

  phase_slip_seq u_phase_slip (
    .core_clk         (core_clk),
    .rst              (rst),
    .ce               (ce),
    .hsync            (hsync),
    .slip_sync_edge   (trim[POS_SYNC_EDGE]),
    .slip_allowed     (slip_allowed),
    .phase_slip_count (trim[POS_PHASE_SLIP +: 3]),
    .slip_pulse       (phase_slip_pulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  // PLL dividers
  logic [31:0] divs;
  assign divs    = pll_regs[IDX_SHARED_DIVIDERS];
  assign pll_div = {divs[POS_REF_DIV +: 8], divs[POS_AUX_FB_DIV +: 8], divs[POS_ENG_FB_DIV +: 8]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_pll_run    <= 1'b0;
      engine_pll_run <= 1'b0;
    end else if (ce) begin
      aux_pll_run    <= div_ok(pll_div.shared_ref_divider) && div_ok(pll_div.aux_pll_feedback_divider);
      engine_pll_run <= div_ok(pll_div.shared_ref_divider) && div_ok(pll_div.engine_pll_feedback_divider);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // DLL and clock source selects, taken straight from the register flops
  logic [31:0] dll_w;
  logic [31:0] fam_w;
  logic [31:0] cap_w;
  logic [31:0] eng_w;
  assign dll_w = pll_regs[IDX_DELAY_LOOP];
  assign fam_w = pll_regs[IDX_AUX_CLOCK_FAMILY];
  assign cap_w = pll_regs[IDX_CAPTURE_CLOCK];
  assign eng_w = pll_regs[IDX_ENGINE_CLOCK];

  // Register order is sleep, reset, band, reference, feedback from bit 0 upward
  assign dll_a = {dll_w[0], dll_w[1], dll_w[3:2], dll_w[5:4], dll_w[7:6]};
  assign dll_b = {dll_w[16], dll_w[17], dll_w[19:18], dll_w[21:20], dll_w[23:22]};

  assign clk_select.aux_clock_source      = fam_w[2:0];
  assign clk_select.second_clock_source   = fam_w[6:4];
  assign clk_select.host_clk_pin_a_source = fam_w[10:8];
  assign clk_select.host_clk_pin_b_source = fam_w[14:12];
  // Source switching safety is left to software
  assign clk_select.engine_clock_source   = eng_w[2:0];
  assign clk_select.capture_clk_a_source  = cap_w[2:0];
  assign clk_select.capture_clk_b_source  = cap_w[POS_CAPTURE_B +: 3];

  clock_gate_ctrl #(
    .N (3)
  ) u_gate (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .force_on  (eng_w[POS_FORCE_2D +: 3]),
    .activity  (engine_activity),
    .clock_run (engine_clock_run)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_pixel_slip_plain: assert property (@(posedge core_clk) disable iff (rst)
    ce && !(legacy_mode && sequencer_half_pixel_clock) && !trim[3]
      |=> line_extra_pixels == {1'b0, $past(trim[2:0])})
    else $error("pixel slip not applied");
  chk_pixel_slip_half: assert property (@(posedge core_clk) disable iff (rst)
    ce && legacy_mode && sequencer_half_pixel_clock && !trim[3]
      |=> line_extra_pixels == {$past(trim[2:0]), 1'b0})
    else $error("pixel slip not doubled in halved mode");
  chk_legacy_block: assert property (@(posedge core_clk) disable iff (rst)
    ce && !extended_display_enable && !trim[POS_LEGACY_EN] |=> !phase_slip_pulse)
    else $error("phase slip in legacy mode while disabled");
  chk_divider_halt: assert property (@(posedge core_clk) disable iff (rst)
    ce && pll_div.shared_ref_divider < MIN_DIVIDER |=> !aux_pll_run && !engine_pll_run)
    else $error("PLL runs with reference divider below two");
  chk_feedback_run: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> engine_pll_run == ($past(pll_div.shared_ref_divider) >= MIN_DIVIDER
                              && $past(pll_div.engine_pll_feedback_divider) >= MIN_DIVIDER))
    else $error("engine PLL run state wrong");
  chk_dll_defaults: assert property (@(posedge core_clk)
    $past(rst) && !rst |-> dll_a.sleep && dll_a.reset && dll_b.sleep && dll_b.reset
      && dll_a.freq_band == BAND_80_110 && dll_b.freq_band == BAND_80_110)
    else $error("DLL defaults wrong after reset");
  chk_capture_ground: assert property (@(posedge core_clk)
    $past(rst) && !rst |-> clk_select.capture_clk_a_source == CAPTURE_GROUND
      && clk_select.capture_clk_b_source == CAPTURE_GROUND)
    else $error("capture selects not ground after reset");
  chk_write_guard: assert property (@(posedge core_clk) disable iff (rst)
    ce && reg_wr && reg_sel_data && !index_wr_en && index_addr == IDX_ENGINE_CLOCK
      |=> $stable(eng_w))
    else $error("data write taken without write enable");
  chk_read_back: assert property (@(posedge core_clk) disable iff (rst)
    ce && reg_rd && reg_sel_data |=> reg_rvalid && reg_rdata == $past(pll_regs[index_addr]))
    else $error("data read returned wrong word");

  cov_phase_slip: cover property (@(posedge core_clk) disable iff (rst) phase_slip_pulse);
  cov_half_mode: cover property (@(posedge core_clk) disable iff (rst) line_extra_pixels == 4'he);
  cov_data_write: cover property (@(posedge core_clk) disable iff (rst) data_write && reg_be == 4'hf);
  cov_pll_run: cover property (@(posedge core_clk) disable iff (rst) aux_pll_run && engine_pll_run);

endmodule : clock_generation_control
`default_nettype wire

// ---- clock_generation_control_bench.sv ----
// Self-checking bench for the clock generation control block
`timescale 1ns/1ns
`default_nettype none
module clock_generation_control_bench;
  import clk_gen_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_sel_data;
  logic [3:0]  reg_be;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        hsync;
  logic        extended_display_enable;
  logic        sequencer_half_pixel_clock;
  logic [3:0]  line_extra_pixels;
  logic        phase_slip_pulse;
  pll_div_t    pll_div;
  logic        aux_pll_run;
  logic        engine_pll_run;
  dll_ctl_t    dll_a;
  dll_ctl_t    dll_b;
  clk_select_t clk_select;
  logic [2:0]  engine_activity;
  logic [2:0]  engine_clock_run;
  int          n_errors;
  int          checks_done;
  logic [31:0] rng;
  logic [31:0] model [0:31];

  clock_generation_control dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel_data(reg_sel_data), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .hsync(hsync), .extended_display_enable(extended_display_enable),
    .sequencer_half_pixel_clock(sequencer_half_pixel_clock), .line_extra_pixels(line_extra_pixels),
    .phase_slip_pulse(phase_slip_pulse), .pll_div(pll_div), .aux_pll_run(aux_pll_run),
    .engine_pll_run(engine_pll_run), .dll_a(dll_a), .dll_b(dll_b), .clk_select(clk_select),
    .engine_activity(engine_activity), .engine_clock_run(engine_clock_run)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [31:0] msk_of(input logic [4:0] i);
    case (i)
      IDX_LINE_TOTAL_TRIM:                     return MSK_LINE_TOTAL_TRIM;
      IDX_SHARED_DIVIDERS:                     return MSK_SHARED_DIVIDERS;
      IDX_AUX_PLL_MACRO, IDX_ENGINE_PLL_MACRO: return MSK_PLL_MACRO;
      IDX_DELAY_LOOP:                          return MSK_DELAY_LOOP;
      IDX_AUX_CLOCK_FAMILY:                    return MSK_AUX_CLOCK_FAMILY;
      IDX_ENGINE_CLOCK:                        return MSK_ENGINE_CLOCK;
      IDX_PORT_PLL:                            return MSK_PORT_PLL;
      IDX_CAPTURE_CLOCK:                       return MSK_CAPTURE_CLOCK;
      IDX_PLL_TEST:                            return MSK_PLL_TEST;
      default:                                 return 32'h0;
    endcase
  endfunction : msk_of

  function automatic logic [31:0] rst_of(input logic [4:0] i);
    case (i)
      IDX_AUX_PLL_MACRO, IDX_ENGINE_PLL_MACRO: return RST_PLL_MACRO;
      IDX_DELAY_LOOP:                          return RST_DELAY_LOOP;
      IDX_PORT_PLL:                            return RST_PORT_PLL;
      IDX_CAPTURE_CLOCK:                       return RST_CAPTURE_CLOCK;
      IDX_PLL_TEST:                            return RST_PLL_TEST;
      default:                                 return 32'h0;
    endcase
  endfunction : rst_of

  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus_wr(input logic sel, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_sel_data <= sel;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic sel, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_sel_data <= sel;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    d = 32'hx;
    for (int k = 0; k < 4; k++) begin
      @(negedge core_clk);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask : bus_rd

  // Index then data; the model merges lanes only when write enable is set
  task automatic put(input logic [4:0] i, input logic [3:0] be, input logic [31:0] d, input logic wen);
    bus_wr(1'b0, 4'h1, {24'h0, wen, 2'b00, i});
    bus_wr(1'b1, be, d);
    for (int b = 0; b < 4; b++) if (wen && be[b]) model[i][8*b +: 8] = d[8*b +: 8];
    model[i] = model[i] & msk_of(i);
  endtask : put

  task automatic get(input logic [4:0] i);
    logic [31:0] d;
    bus_wr(1'b0, 4'h1, {27'h0, i});
    bus_rd(1'b1, d);
    cmp("data register", model[i], d);
  endtask : get

  task automatic check_outs;
    logic [31:0] h, s, x, e, c, dl;
    logic [3:0]  px;
    repeat (3) @(negedge core_clk);
    h = model[IDX_LINE_TOTAL_TRIM];
    s = model[IDX_SHARED_DIVIDERS];
    x = model[IDX_AUX_CLOCK_FAMILY];
    e = model[IDX_ENGINE_CLOCK];
    c = model[IDX_CAPTURE_CLOCK];
    dl = model[IDX_DELAY_LOOP];
    px = (h[3:0] > 4'h7) ? 4'h7 : h[3:0];
    if (!extended_display_enable && sequencer_half_pixel_clock) px = px << 1;
    cmp("line extra pixels", {28'h0, px}, {28'h0, line_extra_pixels});
    cmp("dividers", {8'h0, s[7:0], s[15:8], s[23:16]}, {8'h0, pll_div});
    cmp("pll run", {30'h0, s[7:0] >= 8'h02 && s[15:8] >= 8'h02, s[7:0] >= 8'h02 && s[23:16] >= 8'h02},
        {30'h0, aux_pll_run, engine_pll_run});
    cmp("dll a", {24'h0, dl[0], dl[1], dl[3:2], dl[5:4], dl[7:6]}, {24'h0, dll_a});
    cmp("dll b", {24'h0, dl[16], dl[17], dl[19:18], dl[21:20], dl[23:22]}, {24'h0, dll_b});
    cmp("clock selects", {11'h0, x[2:0], x[6:4], x[10:8], x[14:12], e[2:0], c[2:0], c[10:8]},
        {11'h0, clk_select});
    cmp("engine clock run", {29'h0, e[18:16] | engine_activity}, {29'h0, engine_clock_run});
  endtask : check_outs

  // One selected sync edge, then count the slip pulses that follow
  task automatic slip_case(input logic [2:0] n, input logic edge_sel, input logic vga_en, input logic ext);
    int cnt;
    put(IDX_LINE_TOTAL_TRIM, 4'hf, {3'h0, vga_en, 3'h0, edge_sel, 5'h0, n, 16'h0}, 1'b1);
    @(posedge core_clk);
    extended_display_enable <= ext;
    hsync <= edge_sel;
    repeat (10) @(posedge core_clk);
    hsync <= ~edge_sel;
    cnt = 0;
    repeat (14) begin
      @(negedge core_clk);
      if (phase_slip_pulse === 1'b1) cnt++;
    end
    cmp("phase slip pulses", (ext || vga_en) ? {29'h0, n} : 32'h0, cnt);
  endtask : slip_case

  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Run needs about 4000 cycles; allow well over twice that
  initial begin
    #1000000;
    n_errors++;
    report_and_stop;
  end

  initial begin
    logic [31:0] d;
    n_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel_data = 1'b0;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
    hsync = 1'b0;
    extended_display_enable = 1'b1;
    sequencer_half_pixel_clock = 1'b0;
    engine_activity = 3'h0;
    rng = 32'd69329;
    for (int i = 0; i < 32; i++) model[i] = rst_of(5'(i));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    check_outs;
    for (int i = 0; i < 32; i++) get(5'(i));
    put(IDX_ENGINE_CLOCK, 4'hf, 32'hffff_ffff, 1'b0);
    get(IDX_ENGINE_CLOCK);
    bus_wr(1'b0, 4'h3, 32'hffff_ffff);
    bus_rd(1'b0, d);
    cmp("index register", 32'h0000_039f, d);
    put(IDX_SHARED_DIVIDERS, 4'hf, 32'h0002_0201, 1'b1);
    check_outs;
    put(IDX_SHARED_DIVIDERS, 4'hf, 32'h0001_0202, 1'b1);
    check_outs;
    put(IDX_LINE_TOTAL_TRIM, 4'h1, 32'h0000_000f, 1'b1);
    check_outs;
    put(IDX_SHARED_DIVIDERS, 4'hf, 32'h0040_4010, 1'b1);
    check_outs;
    put(IDX_ENGINE_CLOCK, 4'h1, 32'h0000_0001, 1'b1);
    check_outs;
    for (int t = 0; t < 300; t++) begin
      rng = xs(rng);
      d = rng;
      rng = xs(rng);
      @(posedge core_clk);
      extended_display_enable <= rng[8];
      sequencer_half_pixel_clock <= rng[9];
      engine_activity <= rng[12:10];
      hsync <= rng[13];
      put(rng[4:0], rng[19:16], d, rng[20] | rng[21]);
      get(rng[4:0]);
      check_outs;
    end
    for (int k = 0; k < 8; k++) slip_case(3'(k), k[0], k[1], k[2]);
    slip_case(3'h7, 1'b1, 1'b0, 1'b0);
    report_and_stop;
  end
endmodule : clock_generation_control_bench
`default_nettype wire

// ---- phase_slip_seq.sv ----
// Emits phase slip requests after the selected sync edge
`timescale 1ns/1ns
`default_nettype none
module phase_slip_seq (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       hsync,
  input  wire logic       slip_sync_edge,
  input  wire logic       slip_allowed,
  input  wire logic [2:0] phase_slip_count,
  output var  logic       slip_pulse
);
  import clk_gen_pkg::*;

  logic       hsync_last;
  logic [2:0] remaining;
  logic       sync_hit;

  // Rising edge when select is 0, falling edge when 1
  assign sync_hit = slip_sync_edge ? (hsync_last & ~hsync) : (~hsync_last & hsync);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hsync_last <= 1'b0;
    end else if (ce) begin
      hsync_last <= hsync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      remaining  <= 3'h0;
      slip_pulse <= 1'b0;
    end else if (ce) begin
      if (!slip_allowed) begin
        remaining  <= 3'h0;
        slip_pulse <= 1'b0;
      end else if (sync_hit) begin
        remaining  <= phase_slip_count;
        slip_pulse <= 1'b0;
      end else begin
        slip_pulse <= (remaining != 3'h0);
        remaining  <= (remaining != 3'h0) ? remaining - 3'h1 : 3'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  chk_slip_load: assert property (@(posedge core_clk) disable iff (rst)
    ce && slip_allowed && sync_hit |=> remaining == $past(phase_slip_count))
    else $error("slip count not loaded on sync edge");
  chk_edge_choice: assert property (@(posedge core_clk) disable iff (rst)
    ce && slip_allowed && !slip_sync_edge && $fell(hsync) && !$past(rst) |=> remaining == 3'h0
      || $past(remaining) != 3'h0)
    else $error("falling edge taken while rising edge selected");
  chk_slip_count: assert property (@(posedge core_clk) disable iff (rst)
    ce && slip_allowed && sync_hit && phase_slip_count == 3'h2 ##1 (ce && slip_allowed && !sync_hit)[*3]
      |-> slip_pulse && $past(slip_pulse) && !$past(slip_pulse, 2))
    else $error("wrong number of phase slips");
  cov_slip_burst: cover property (@(posedge core_clk) disable iff (rst) slip_pulse [*3]);

endmodule : phase_slip_seq
`default_nettype wire
